/* File: design/ssb_consts.svh */
// constants for the power-down and subtract-with-borrow execution block
`ifndef SSB_CONSTS_SVH
`define SSB_CONSTS_SVH

// opcodes
`define SSB_OPC_SLEEP       16'h0003
`define SSB_OPC_SUB_HI      6'h15
`define SSB_OPC_SUB_HI_POS  10
`define SSB_OPC_DEST_POS    9
`define SSB_OPC_BANK_POS    8

// addressing
`define SSB_ACCESS_SPLIT    8'h80
`define SSB_ACCESS_HI_BANK  4'hf
`define SSB_ACCESS_LO_BANK  4'h0
`define SSB_INDEX_LIMIT     8'h5f
`define SSB_ADDR_W          12
`define SSB_MEM_DEPTH       4096

// register offsets
`define SSB_REG_CTRL        4'h0
`define SSB_REG_WREG        4'h1
`define SSB_REG_STATUS      4'h2
`define SSB_REG_BANK_SEL    4'h3
`define SSB_REG_FSR2_LO     4'h4
`define SSB_REG_FSR2_HI     4'h5
`define SSB_REG_POWER       4'h6
`define SSB_REG_MEM_LO      4'h8
`define SSB_REG_MEM_HI      4'h9
`define SSB_REG_MEM_DATA    4'ha

// field positions
`define SSB_CTRL_EXT_POS    0
`define SSB_POWER_PWRDN_POS 0
`define SSB_POWER_TMOUT_POS 1

// reset values
`define SSB_RST_BYTE        8'h00
`define SSB_RST_ADDR        12'h000
`define SSB_RST_PWRDN       1'b1
`define SSB_RST_TMOUT       1'b1

`endif

/* File: design/ssb_pkg.sv */
// types for the power-down and subtract-with-borrow execution block
package ssb_pkg;

	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} ssb_phase_e;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_SLEEP,
		OP_SUB
	} ssb_op_e;

	typedef struct packed {
		logic n;
		logic overflow_flag;
		logic z;
		logic digit_carry_flag;
		logic c;
	} ssb_flags_s;

	typedef struct packed {
		logic [7:0] res;
		ssb_flags_s fl;
	} ssb_alu_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ssb_bus_req_s;

	typedef struct packed {
		logic        we;
		logic [11:0] addr;
		logic [7:0]  data;
	} ssb_file_wr_s;

endpackage

/* File: design/ssb_file_mem.sv */
// data register file: one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none
`include "ssb_consts.svh"

module ssb_file_mem
(
	// clock
	input  wire logic                    ref_clk,
	// write port
	input  wire logic                    we,
	input  wire logic [`SSB_ADDR_W-1:0]  wa,
	input  wire logic [7:0]              wd,
	// read ports
	input  wire logic [`SSB_ADDR_W-1:0]  ra_a,
	input  wire logic [`SSB_ADDR_W-1:0]  ra_b,
	output logic      [7:0]              rd_a,
	output logic      [7:0]              rd_b
);

	logic [7:0] mem_r [0:`SSB_MEM_DEPTH-1];

	// contents are not reset; software preloads what it needs
	always_ff @(posedge ref_clk)
	begin
		if (we)
			mem_r[wa] <= wd;
		rd_a <= mem_r[ra_a];
		rd_b <= mem_r[ra_b];
	end

endmodule // ssb_file_mem

`default_nettype wire

/* File: design/ssb_exec.sv */
// execution of power-down entry and subtract-with-borrow instructions
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ssb_consts.svh"

// Notes on behaviour
// - opcode 0003h decodes as power-down entry
// - power-down entry clears powerdown status bit
// - power-down entry sets timeout status bit
// - power-down entry clears watchdog counter and postscaler
// - sleep with oscillator halted, entered in Q4
// - watchdog wake clears the timeout status bit
// - W minus f minus inverted carry, flags
// - dest bit 0 writes W, 1 writes f
// - bank bit 0 access bank, else bank register
// - extended set, bank 0, f<=5Fh: indexed
module ssb_exec
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	// instruction fetch
	input  wire logic [15:0]          opcode,
	input  wire logic                 opcode_valid,
	output ssb_pkg::ssb_phase_e       phase_r,
	output logic                      fetch_ack_r,
	// wake-up sources
	input  wire logic                 wake_watchdog,
	input  wire logic                 wake_other,
	// power and watchdog
	output logic                      sleep_r,
	output logic                      watchdog_counter_clear_r,
	output logic                      powerdown_status_bit_r,
	output logic                      timeout_status_bit_r,
	// register file write trace
	output ssb_pkg::ssb_file_wr_s     file_wr_r,
	// register port
	input  wire ssb_pkg::ssb_bus_req_s bus_req,
	output logic [7:0]                rdata_r
);

	// core state
	ssb_pkg::ssb_phase_e  phase_nxt;
	ssb_pkg::ssb_op_e     op_r;
	ssb_pkg::ssb_op_e     op_nxt;
	logic                 dest_r;
	logic                 dest_nxt;
	logic [11:0]          eff_addr_r;
	logic [11:0]          eff_addr_nxt;
	ssb_pkg::ssb_alu_s    alu_r;
	ssb_pkg::ssb_alu_s    alu_nxt;
	logic [7:0]           w_r;
	logic [7:0]           w_nxt;
	ssb_pkg::ssb_flags_s  flags_r;
	ssb_pkg::ssb_flags_s  flags_nxt;
	logic                 sleep_nxt;
	logic                 watchdog_counter_clear_nxt;
	logic                 powerdown_status_bit_nxt;
	logic                 timeout_status_bit_nxt;
	logic                 fetch_ack_nxt;
	ssb_pkg::ssb_file_wr_s file_wr_nxt;

	// configuration state
	logic                 ext_en_r;
	logic                 ext_en_nxt;
	logic [3:0]           bank_select_register_r;
	logic [3:0]           bank_select_register_nxt;
	logic [11:0]          fsr2_r;
	logic [11:0]          fsr2_nxt;
	logic [11:0]          mem_addr_r;
	logic [11:0]          mem_addr_nxt;
	logic [7:0]           rdata_nxt;

	// memory ports
	logic                 mem_we;
	logic [11:0]          mem_wa;
	logic [7:0]           mem_wd;
	logic [7:0]           mem_rd_a;
	logic [7:0]           mem_rd_b;

	logic                 bus_mem_wr;
	logic                 sleep_fire;
	logic                 sub_fire;

	// effective data address of a byte-oriented operand
	function automatic logic [11:0] eff_addr(
		input logic [7:0]  f,
		input logic        a,
		input logic        ext,
		input logic [3:0]  bank,
		input logic [11:0] fsr2
	);
		logic [11:0] r;
		r = {bank, f};
		if (!a)
		begin
			if (ext && f <= `SSB_INDEX_LIMIT)
				r = 12'(fsr2 + {4'h0, f});
			else if (f < `SSB_ACCESS_SPLIT)
				r = {`SSB_ACCESS_LO_BANK, f};
			else
				r = {`SSB_ACCESS_HI_BANK, f};
		end
		return r;
	endfunction

	// W - f - !C in two's complement
	function automatic ssb_pkg::ssb_alu_s sub_borrow(
		input logic [7:0] w,
		input logic [7:0] f,
		input logic       c
	);
		ssb_pkg::ssb_alu_s o;
		logic [8:0] full;
		logic [4:0] half;
		full = {1'b0, w} - {1'b0, f} - {8'h00, ~c};
		half = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, ~c};
		o.res = full[7:0];
		o.fl.c = ~full[8];
		o.fl.digit_carry_flag = ~half[4];
		o.fl.z = (full[7:0] == 8'h00);
		o.fl.n = full[7];
		o.fl.overflow_flag = (w[7] ^ f[7]) & (w[7] ^ full[7]);
		return o;
	endfunction

	assign bus_mem_wr = bus_req.wr && bus_req.addr == `SSB_REG_MEM_DATA;
	assign sleep_fire = phase_r == ssb_pkg::PH_Q4 && op_r == ssb_pkg::OP_SLEEP;
	assign sub_fire   = phase_r == ssb_pkg::PH_Q4 && op_r == ssb_pkg::OP_SUB;

	// core writes win the single write port over the register port
	assign mem_we = file_wr_r.we | bus_mem_wr;
	assign mem_wa = file_wr_r.we ? file_wr_r.addr : mem_addr_r;
	assign mem_wd = file_wr_r.we ? file_wr_r.data : bus_req.wdata;

	ssb_file_mem u_file
	(
		.ref_clk (ref_clk),
		.we      (mem_we),
		.wa      (mem_wa),
		.wd      (mem_wd),
		.ra_a    (eff_addr_r),
		.ra_b    (mem_addr_r),
		.rd_a    (mem_rd_a),
		.rd_b    (mem_rd_b)
	);

	// core: phases, decode, execute, power-down
	always_comb
	begin
		phase_nxt = phase_r;
		op_nxt = op_r;
		dest_nxt = dest_r;
		eff_addr_nxt = eff_addr_r;
		alu_nxt = alu_r;
		w_nxt = w_r;
		flags_nxt = flags_r;
		sleep_nxt = sleep_r;
		watchdog_counter_clear_nxt = 1'b0;
		powerdown_status_bit_nxt = powerdown_status_bit_r;
		timeout_status_bit_nxt = timeout_status_bit_r;
		fetch_ack_nxt = 1'b0;
		file_wr_nxt = '0;
		file_wr_nxt.addr = file_wr_r.addr;
		file_wr_nxt.data = file_wr_r.data;

		if (bus_req.wr && bus_req.addr == `SSB_REG_WREG)
			w_nxt = bus_req.wdata;
		if (bus_req.wr && bus_req.addr == `SSB_REG_STATUS)
			flags_nxt = bus_req.wdata[4:0];

		if (sleep_r)
		begin
			// clock halted: phases hold until a wake source fires
			if (wake_watchdog)
			begin
				sleep_nxt = 1'b0;
				timeout_status_bit_nxt = 1'b0;
			end
			else if (wake_other)
				sleep_nxt = 1'b0;
		end
		else
		begin
			case (phase_r)
				ssb_pkg::PH_Q1:
				begin
					phase_nxt = ssb_pkg::PH_Q2;
					op_nxt = ssb_pkg::OP_NONE;
					if (opcode_valid)
					begin
						fetch_ack_nxt = 1'b1;
						if (opcode == `SSB_OPC_SLEEP)
							op_nxt = ssb_pkg::OP_SLEEP;
						else if (opcode[15:`SSB_OPC_SUB_HI_POS]
							== `SSB_OPC_SUB_HI)
							op_nxt = ssb_pkg::OP_SUB;
					end
					dest_nxt = opcode[`SSB_OPC_DEST_POS];
					eff_addr_nxt = eff_addr(opcode[7:0],
						opcode[`SSB_OPC_BANK_POS], ext_en_r,
						bank_select_register_r, fsr2_r);
				end
				ssb_pkg::PH_Q2:
					phase_nxt = ssb_pkg::PH_Q3;
				ssb_pkg::PH_Q3:
				begin
					phase_nxt = ssb_pkg::PH_Q4;
					alu_nxt = sub_borrow(w_r, mem_rd_a, flags_r.c);
				end
				ssb_pkg::PH_Q4:
				begin
					phase_nxt = ssb_pkg::PH_Q1;
					if (op_r == ssb_pkg::OP_SUB)
					begin
						flags_nxt = alu_r.fl;
						if (dest_r)
						begin
							file_wr_nxt.we = 1'b1;
							file_wr_nxt.addr = eff_addr_r;
							file_wr_nxt.data = alu_r.res;
						end
						else
							w_nxt = alu_r.res;
					end
					else if (op_r == ssb_pkg::OP_SLEEP)
					begin
						powerdown_status_bit_nxt = 1'b0;
						timeout_status_bit_nxt = 1'b1;
						watchdog_counter_clear_nxt = 1'b1;
						sleep_nxt = 1'b1;
					end
				end
				default:
					phase_nxt = ssb_pkg::PH_Q1;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			phase_r <= ssb_pkg::PH_Q1;
			op_r <= ssb_pkg::OP_NONE;
			dest_r <= 1'b0;
			eff_addr_r <= `SSB_RST_ADDR;
			alu_r <= '0;
			w_r <= `SSB_RST_BYTE;
			flags_r <= '0;
			sleep_r <= 1'b0;
			watchdog_counter_clear_r <= 1'b0;
			powerdown_status_bit_r <= `SSB_RST_PWRDN;
			timeout_status_bit_r <= `SSB_RST_TMOUT;
			fetch_ack_r <= 1'b0;
			file_wr_r <= '0;
		end
		else
		begin
			phase_r <= phase_nxt;
			op_r <= op_nxt;
			dest_r <= dest_nxt;
			eff_addr_r <= eff_addr_nxt;
			alu_r <= alu_nxt;
			w_r <= w_nxt;
			flags_r <= flags_nxt;
			sleep_r <= sleep_nxt;
			watchdog_counter_clear_r <= watchdog_counter_clear_nxt;
			powerdown_status_bit_r <= powerdown_status_bit_nxt;
			timeout_status_bit_r <= timeout_status_bit_nxt;
			fetch_ack_r <= fetch_ack_nxt;
			file_wr_r <= file_wr_nxt;
		end
	end

	// register port: configuration and read-back
	always_comb
	begin
		ext_en_nxt = ext_en_r;
		bank_select_register_nxt = bank_select_register_r;
		fsr2_nxt = fsr2_r;
		mem_addr_nxt = mem_addr_r;
		rdata_nxt = `SSB_RST_BYTE;
		if (bus_req.wr)
		begin
			case (bus_req.addr)
				`SSB_REG_CTRL:
					ext_en_nxt = bus_req.wdata[`SSB_CTRL_EXT_POS];
				`SSB_REG_BANK_SEL:
					bank_select_register_nxt = bus_req.wdata[3:0];
				`SSB_REG_FSR2_LO:
					fsr2_nxt[7:0] = bus_req.wdata;
				`SSB_REG_FSR2_HI:
					fsr2_nxt[11:8] = bus_req.wdata[3:0];
				`SSB_REG_MEM_LO:
					mem_addr_nxt[7:0] = bus_req.wdata;
				`SSB_REG_MEM_HI:
					mem_addr_nxt[11:8] = bus_req.wdata[3:0];
				default:
					mem_addr_nxt = mem_addr_r;
			endcase
		end
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				`SSB_REG_CTRL:
					rdata_nxt = {7'h00, ext_en_r};
				`SSB_REG_WREG:
					rdata_nxt = w_r;
				`SSB_REG_STATUS:
					rdata_nxt = {3'h0, flags_r};
				`SSB_REG_BANK_SEL:
					rdata_nxt = {4'h0, bank_select_register_r};
				`SSB_REG_FSR2_LO:
					rdata_nxt = fsr2_r[7:0];
				`SSB_REG_FSR2_HI:
					rdata_nxt = {4'h0, fsr2_r[11:8]};
				`SSB_REG_POWER:
					rdata_nxt = {6'h00, timeout_status_bit_r,
						powerdown_status_bit_r};
				`SSB_REG_MEM_LO:
					rdata_nxt = mem_addr_r[7:0];
				`SSB_REG_MEM_HI:
					rdata_nxt = {4'h0, mem_addr_r[11:8]};
				`SSB_REG_MEM_DATA:
					rdata_nxt = mem_rd_b;
				default:
					rdata_nxt = `SSB_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ext_en_r <= 1'b0;
			bank_select_register_r <= 4'h0;
			fsr2_r <= `SSB_RST_ADDR;
			mem_addr_r <= `SSB_RST_ADDR;
			rdata_r <= `SSB_RST_BYTE;
		end
		else
		begin
			ext_en_r <= ext_en_nxt;
			bank_select_register_r <= bank_select_register_nxt;
			fsr2_r <= fsr2_nxt;
			mem_addr_r <= mem_addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	a_sleep_decode: assert property (
		phase_r == ssb_pkg::PH_Q1 && !sleep_r && opcode_valid
		&& opcode == 16'h0003 |=> op_r == ssb_pkg::OP_SLEEP ##2 sleep_fire)
		else $error("power-down opcode not decoded");

	a_powerdown_clear: assert property (
		sleep_fire |=> !powerdown_status_bit_r && sleep_r)
		else $error("powerdown status not cleared");

	a_timeout_set: assert property (
		sleep_fire && !wake_watchdog |=> timeout_status_bit_r)
		else $error("timeout status not set");

	a_watchdog_clear: assert property (
		sleep_fire |=> watchdog_counter_clear_r
		##1 !watchdog_counter_clear_r)
		else $error("watchdog clear pulse wrong");

	a_sleep_entry: assert property (
		$rose(sleep_r) |-> $past(sleep_fire) && phase_r == ssb_pkg::PH_Q1)
		else $error("sleep entered outside Q4");

	a_wake_timeout: assert property (
		sleep_r && wake_watchdog |=> !timeout_status_bit_r && !sleep_r)
		else $error("watchdog wake left timeout set");

	a_sub_result: assert property (
		sub_fire && !dest_r |=> w_r == $past(alu_r.res)
		&& flags_r == $past(alu_r.fl))
		else $error("subtract result not in W");

	a_dest_file: assert property (
		sub_fire && dest_r |=> file_wr_r.we
		&& file_wr_r.addr == $past(eff_addr_r) && w_r == $past(w_r))
		else $error("subtract result not in file");

	a_bank_sel: assert property (
		phase_r == ssb_pkg::PH_Q1 && !sleep_r && opcode_valid
		&& opcode[8] |=> eff_addr_r
		== {$past(bank_select_register_r), $past(opcode[7:0])})
		else $error("bank register not used");

	a_indexed: assert property (
		phase_r == ssb_pkg::PH_Q1 && !sleep_r && !opcode[8] && ext_en_r
		&& opcode[7:0] <= 8'h5f |=> eff_addr_r
		== 12'($past(fsr2_r) + {4'h0, $past(opcode[7:0])}))
		else $error("indexed offset address wrong");

	a_phase_cycle: assert property (
		phase_r == ssb_pkg::PH_Q1 && !sleep_r |=> phase_r == ssb_pkg::PH_Q2
		##1 phase_r == ssb_pkg::PH_Q3 ##1 phase_r == ssb_pkg::PH_Q4
		##1 phase_r == ssb_pkg::PH_Q1)
		else $error("instruction cycle not four phases");

endmodule // ssb_exec

`default_nettype wire

/* File: bench/ssb_fetch_model.sv */
// program memory fetch model feeding instruction words to the core
`timescale 1ns/1ps
`default_nettype none

module ssb_fetch_model
(
	// clock
	input  wire logic        ref_clk,
	// bench side
	input  wire logic        go,
	input  wire logic [15:0] word,
	// core side
	output logic             opcode_valid,
	output logic [15:0]      opcode
);
	logic [15:0] junk_r = 16'ha5c3;

	// an idle fetch bus flips every cycle, so a stale word is never a match
	always_ff @(posedge ref_clk)
		junk_r <= ~junk_r;

	assign opcode_valid = go;
	assign opcode       = go ? word : junk_r;
endmodule // ssb_fetch_model

`default_nettype wire

/* File: bench/test_sleep_and_subtract_borrow_exec.sv */
// self-checking bench for the power-down and subtract-with-borrow block
`timescale 1ns/1ps
`default_nettype none
`include "ssb_consts.svh"

module test_sleep_and_subtract_borrow_exec;
	logic                  ref_clk, reset, go, wake_wdog, wake_other;
	logic                  opcode_valid, fetch_ack_r, sleep_r;
	logic                  wdog_clr, pwrdn, tmout, d, a, ext, c;
	logic [15:0]           word, opcode;
	logic [7:0]            rdata_r, w, f, fv, r8, b8;
	logic [11:0]           fsr, ea;
	logic [4:0]            fl;
	logic [31:0]           seed = 32'h45c84d49;
	ssb_pkg::ssb_phase_e   phase_r;
	ssb_pkg::ssb_file_wr_s file_wr_r, fw;
	ssb_pkg::ssb_bus_req_s bus_req;
	int                    n_errors, check_count, r;
	logic [15:0]           odd_ops [4] = '{16'h0002, 16'h0007, 16'h0103,
	                                       16'h5c00};
	logic [7:0]            edge_f [4] = '{8'h5f, 8'h60, 8'h7f, 8'h80};

	ssb_fetch_model ssb_fetch_model_inst
	(
		.ref_clk      (ref_clk),
		.go           (go),
		.word         (word),
		.opcode_valid (opcode_valid),
		.opcode       (opcode)
	);

	ssb_exec ssb_exec_inst
	(
		.ref_clk      (ref_clk),
		.reset        (reset),
		.opcode       (opcode),
		.opcode_valid (opcode_valid),
		.phase_r      (phase_r),
		.fetch_ack_r  (fetch_ack_r),
		.wake_watchdog            (wake_wdog),
		.wake_other               (wake_other),
		.sleep_r                  (sleep_r),
		.watchdog_counter_clear_r (wdog_clr),
		.powerdown_status_bit_r   (pwrdn),
		.timeout_status_bit_r     (tmout),
		.file_wr_r    (file_wr_r),
		.bus_req      (bus_req),
		.rdata_r      (rdata_r)
	);

	function automatic logic [7:0] rnd8();
		repeat (8)
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bw(input logic [3:0] ad, input logic [7:0] dt);
		@(posedge ref_clk);
		bus_req <= '{addr: ad, wdata: dt, wr: 1'h1, rd: 1'h0};
		@(posedge ref_clk);
		bus_req <= '0;
	endtask

	task automatic rc(input logic [3:0] ad, input logic [7:0] e);
		@(posedge ref_clk);
		bus_req <= '{addr: ad, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge ref_clk);
		bus_req <= '0;
		#1 chk(rdata_r, e);
	endtask

	// phase is looked at once settled; Q4 now means the next edge opens Q1
	task automatic run(input logic [15:0] o);
		int k;
		k = 0;
		@(posedge ref_clk);
		#1;
		while (phase_r !== ssb_pkg::PH_Q4 && k < 8)
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		chk(k < 8, 1'h1);
		@(posedge ref_clk);
		word <= o;
		go <= 1'h1;
		@(posedge ref_clk);
		go <= 1'h0;
		#1 chk({fetch_ack_r, phase_r}, {1'h1, ssb_pkg::PH_Q2});
		repeat (3) @(posedge ref_clk);
		#1 fw = file_wr_r;
	endtask

	task automatic wake(input logic wd);
		@(posedge ref_clk);
		go <= 1'h0;
		wake_wdog <= wd;
		wake_other <= !wd;
		@(posedge ref_clk);
		wake_wdog <= 1'h0;
		wake_other <= 1'h0;
		#1;
	endtask

	task end_of_test;
		$display("n_errors=%0d check_count=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial
	begin
		#200000;
		n_errors++;
		end_of_test;
	end

	initial
	begin
		reset = 1'h1;
		go = 1'h0;
		word = 16'h0000;
		wake_wdog = 1'h0;
		wake_other = 1'h0;
		bus_req = '0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'h0;
		rc(`SSB_REG_POWER, 8'h03);
		bw(`SSB_REG_POWER, 8'h00);
		rc(`SSB_REG_POWER, 8'h03);
		bw(4'h7, 8'hff);
		rc(4'h7, 8'h00);
		@(posedge ref_clk);
		#1 chk(rdata_r, 8'h00);
		rc(`SSB_REG_STATUS, 8'h00);
		foreach (odd_ops[j])
		begin
			run(odd_ops[j]);
			chk({fw.we, sleep_r, wdog_clr}, 3'h0);
		end
		// first four passes sit on the indexed and access-bank boundaries
		for (int i = 0; i < 16; i++)
		begin
			w = rnd8();
			f = rnd8();
			fv = rnd8();
			r8 = rnd8();
			b8 = rnd8();
			fsr = {b8[7:4], rnd8()};
			{d, a, ext, c} = r8[3:0];
			if (i < 4)
			begin
				f = edge_f[i];
				{a, ext} = 2'h1;
			end
			if (a)
				ea = {b8[3:0], f};
			else if (ext && f <= 8'h5f)
				ea = fsr + {4'h0, f};
			else
				ea = {{4{f[7]}}, f};
			bw(`SSB_REG_CTRL, {7'h00, ext});
			bw(`SSB_REG_WREG, w);
			bw(`SSB_REG_STATUS, {7'h00, c});
			bw(`SSB_REG_BANK_SEL, {4'h0, b8[3:0]});
			bw(`SSB_REG_FSR2_LO, fsr[7:0]);
			bw(`SSB_REG_FSR2_HI, {4'h0, fsr[11:8]});
			bw(`SSB_REG_MEM_LO, ea[7:0]);
			bw(`SSB_REG_MEM_HI, {4'h0, ea[11:8]});
			bw(`SSB_REG_MEM_DATA, fv);
			r = int'(w) - int'(fv) - int'(!c);
			r8 = r[7:0];
			fl = {r8[7], w[7] != fv[7] && r8[7] != w[7], r8 == 8'h00,
				int'(w[3:0]) - int'(fv[3:0]) - int'(!c) >= 0, r >= 0};
			run({`SSB_OPC_SUB_HI, d, a, f});
			if (d)
				chk({fw.we, fw.addr, fw.data}, {1'h1, ea, r8});
			else
				chk(fw.we, 1'h0);
			rc(`SSB_REG_WREG, d ? w : r8);
			rc(`SSB_REG_STATUS, {3'h0, fl});
			rc(`SSB_REG_MEM_DATA, d ? r8 : fv);
			if (d && !a && ext && f <= 8'h5f)
				chk(fw.addr, ea);
		end
		run(`SSB_OPC_SLEEP);
		chk({pwrdn, tmout, fw.we}, 3'h2);
		chk(wdog_clr, 1'h1);
		chk(sleep_r, 1'h1);
		@(posedge ref_clk);
		word <= {`SSB_OPC_SUB_HI, 10'h001};
		go <= 1'h1;
		#1 chk(wdog_clr, 1'h0);
		repeat (5) @(posedge ref_clk);
		#1 chk({fetch_ack_r, sleep_r, phase_r}, {2'h1, ssb_pkg::PH_Q1});
		wake(1'h0);
		chk({sleep_r, pwrdn, tmout}, 3'h1);
		rc(`SSB_REG_POWER, 8'h02);
		run(`SSB_OPC_SLEEP);
		wake(1'h1);
		chk({sleep_r, pwrdn, tmout}, 3'h0);
		rc(`SSB_REG_POWER, 8'h00);
		end_of_test;
	end
endmodule // test_sleep_and_subtract_borrow_exec

`default_nettype wire
